// ---- pkg/dsp_list_params.svh ----
// offsets, field positions and reset values of the list control block
`ifndef DSP_LIST_PARAMS_SVH
`define DSP_LIST_PARAMS_SVH
`define RAM_BASE 32'hFFFE0000
`define RAM_END 32'hFFFE1000
`define DED_BASE 32'hFFFF8000
`define DED_END 32'hFFFF8028
`define CTL_BASE 32'hFFFF9000
`define CTL_END 32'hFFFF9018
`define LOOP_ADDR 32'hFFFF8018
`define LIST_PTR_ADDR 32'hFFFF8020
`define EXEC_STATUS_ADDR 32'hFFFF9000
`define ABORT_ADDR 32'hFFFF9004
`define IRQ_STATUS_ADDR 32'hFFFF9008
`define IRQ_MASK_ADDR 32'hFFFF900C
`define GATE_ADDR 32'hFFFF9010
`define NM_SOURCE_ADDR 32'hFFFF9014
`define RUN_BIT 0
`define HALT_BIT 0
`define HOLD_BIT 0
`define NM_PIN_BIT 0
`define NM_ILLEGAL_BIT 1
`define NM_FAULT_BIT 2
`define COUNT_LSB 0
`define COUNT_MSB 15
`define TARGET_LSB 16
`define TARGET_MSB 31
`define REG16_RESET 16'h0000
`define REG32_RESET 32'h00000000
`endif

// ---- pkg/dsp_list_pkg.sv ----
// types shared by the list control block
package dsp_list_pkg;
    typedef enum logic [1:0] {RG_NONE, RG_RAM, RG_DED, RG_CTL} region_e;
    typedef enum logic {ST_IDLE, ST_RUN} exec_state_e;
    typedef logic [31:0] word_t;
    typedef logic [15:0] half_t;
endpackage : dsp_list_pkg

// ---- sim/dsp_list_control_status_tb.sv ----
// self-checking bench of the list control and status registers
`timescale 1ns/100ps
`default_nettype none
`include "dsp_list_params.svh"
module dsp_list_control_status_tb;
    import dsp_list_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    word_t host_addr, host_wdata, host_rdata, loop_value, loop_load_data, v, w;
    logic host_wr, host_rd, host_rack, list_start, list_abort_pulse, overflow_clear;
    logic engine_done = 1'b0, loop_load = 1'b0, decrement_jump_nonzero_step = 1'b0, offchip_req = 1'b0;
    logic illegal_op = 1'b0, nmi_pin_n = 1'b1;
    logic offchip_go, list_stalled, list_running, interrupt_out_pin_n, nmi_request;
    half_t list_pointer, p;
    word_t exp_q[$];
    int miscompares = 0;
    int num_checks = 0;
    initial loop_load_data = 32'h00000000;
    // 50 ns period
    always #25 sys_clk = ~sys_clk;
    dsp_list_control_status u_dsp_list_control_status (.sys_clk(sys_clk), .rst(rst),
        .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rack(host_rack),
        .list_start(list_start), .list_pointer(list_pointer),
        .list_abort_pulse(list_abort_pulse), .overflow_clear(overflow_clear),
        .engine_done(engine_done), .loop_load(loop_load), .loop_load_data(loop_load_data),
        .decrement_jump_nonzero_step(decrement_jump_nonzero_step), .loop_value(loop_value), .offchip_req(offchip_req),
        .offchip_go(offchip_go), .list_stalled(list_stalled), .illegal_op(illegal_op),
        .nmi_pin_n(nmi_pin_n), .list_running(list_running),
        .interrupt_out_pin_n(interrupt_out_pin_n), .nmi_request(nmi_request));
    host_bus_model u_host_bus_model (.sys_clk(sys_clk), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata));
    task automatic chk(input word_t seen, input word_t exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // note the expected answer, then issue the read
    task automatic rd(input word_t a, input word_t e);
        exp_q.push_back(e);
        u_host_bus_model.read(a);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle
    // one-cycle pulse on the engine inputs picked by sel:
    // bit 0 step, bit 1 load, bit 2 done, bit 3 illegal
    task automatic pulse(input logic [3:0] sel);
        @(posedge sys_clk);
        {illegal_op, engine_done, loop_load, decrement_jump_nonzero_step} <= sel;
        @(posedge sys_clk);
        {illegal_op, engine_done, loop_load, decrement_jump_nonzero_step} <= 4'h0;
        settle(3);
    endtask : pulse
    // answers are matched in issue order; an unasked answer is a mismatch
    always @(posedge sys_clk) begin
        if (host_rack === 1'b1) begin
            if (exp_q.size() == 0) chk(32'(host_rack), 32'h00000000);
            else chk(host_rdata, exp_q.pop_front());
        end
    end
    // hang guard at 5000 cycles, well beyond the 140 or so cycles of the sequence
    initial begin
        #(50 * 5000);
        miscompares++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        void'($urandom(70908));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        settle(1);
        chk(32'(interrupt_out_pin_n), 32'h00000001);
        chk(32'(nmi_request), 32'h00000000);
        rd(`EXEC_STATUS_ADDR, 32'h00000000);
        rd(`IRQ_STATUS_ADDR, 32'h00000000);
        rd(`IRQ_MASK_ADDR, 32'h00000000);
        rd(`GATE_ADDR, 32'h00000000);
        rd(`NM_SOURCE_ADDR, 32'h00000000);
        rd(`ABORT_ADDR, 32'h00000000);
        rd(`CTL_END, 32'h00000000);
        v = $urandom();
        w = $urandom();
        u_host_bus_model.write(`LOOP_ADDR, v);
        pulse(4'h1);
        rd(`LOOP_ADDR, {v[31:16], v[15:0] - 16'h0001});
        @(posedge sys_clk);
        loop_load_data <= w;
        pulse(4'h2);
        chk(loop_value, w);
        rd(`LOOP_ADDR, w);
        u_host_bus_model.write(`IRQ_MASK_ADDR, 32'h00000001);
        u_host_bus_model.write(`GATE_ADDR, 32'h00000001);
        rd(`IRQ_MASK_ADDR, 32'h00000001);
        rd(`GATE_ADDR, 32'h00000001);
        @(posedge sys_clk);
        offchip_req <= 1'b1;
        settle(3);
        chk(32'({list_stalled, offchip_go}), 32'h00000002);
        u_host_bus_model.write(`GATE_ADDR, 32'h00000000);
        settle(3);
        chk(32'({list_stalled, offchip_go}), 32'h00000001);
        @(posedge sys_clk);
        offchip_req <= 1'b0;
        p = 16'($urandom());
        u_host_bus_model.write(`LIST_PTR_ADDR, {16'h0000, p});
        settle(0);
        chk(32'(list_start), 32'h00000001);
        settle(1);
        chk(32'(list_pointer), 32'(p));
        chk(32'(list_running), 32'h00000001);
        rd(`EXEC_STATUS_ADDR, 32'h00000001);
        rd(`LOOP_ADDR, 32'h00000000);
        u_host_bus_model.write(`LOOP_ADDR, ~w);
        settle(3);
        chk(32'(nmi_request), 32'h00000001);
        rd(`NM_SOURCE_ADDR, 32'h00000004);
        rd(`NM_SOURCE_ADDR, 32'h00000000);
        pulse(4'h4);
        chk(32'(interrupt_out_pin_n), 32'h00000000);
        chk(32'(list_running), 32'h00000000);
        rd(`EXEC_STATUS_ADDR, 32'h00000000);
        rd(`LOOP_ADDR, w);
        rd(`IRQ_STATUS_ADDR, 32'h00000001);
        rd(`IRQ_STATUS_ADDR, 32'h00000000);
        // a second run sets halt again, a third is aborted with halt still set
        u_host_bus_model.write(`GATE_ADDR, 32'h00000001);
        u_host_bus_model.write(`LIST_PTR_ADDR, 32'h00000010);
        pulse(4'h4);
        chk(32'(interrupt_out_pin_n), 32'h00000000);
        u_host_bus_model.write(`LIST_PTR_ADDR, 32'h00000020);
        u_host_bus_model.write(`ABORT_ADDR, $urandom());
        settle(0);
        chk(32'({list_abort_pulse, overflow_clear}), 32'h00000003);
        settle(3);
        chk(32'(interrupt_out_pin_n), 32'h00000001);
        pulse(4'h4);
        rd(`EXEC_STATUS_ADDR, 32'h00000000);
        rd(`IRQ_MASK_ADDR, 32'h00000000);
        rd(`GATE_ADDR, 32'h00000000);
        rd(`IRQ_STATUS_ADDR, 32'h00000000);
        @(posedge sys_clk);
        nmi_pin_n <= 1'b0;
        pulse(4'h8);
        settle(3);
        rd(`NM_SOURCE_ADDR, 32'h00000003);
        settle(4);
        chk(32'(exp_q.size()), 32'h00000000);
        tally_and_finish();
    end
endmodule : dsp_list_control_status_tb
`default_nettype wire

// ---- sim/host_bus_model.sv ----
// host core model issuing word reads and writes on the strobe bus
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
    input wire logic sys_clk,
    output dsp_list_pkg::word_t host_addr,
    output logic host_wr,
    output logic host_rd,
    output dsp_list_pkg::word_t host_wdata
);
    import dsp_list_pkg::*;
    // bus idle from time zero
    initial begin
        host_addr = 32'h00000000;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 32'h00000000;
    end
    // one write, strobe held for the single taking edge
    task automatic write(input word_t a, input word_t d);
        @(posedge sys_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge sys_clk);
        host_wr <= 1'b0;
        host_addr <= ~a; // released lines never keep the stale value
        host_wdata <= ~d;
    endtask : write
    // one read; the answer is collected by the bench monitor
    task automatic read(input word_t a);
        @(posedge sys_clk);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge sys_clk);
        host_rd <= 1'b0;
        host_addr <= ~a;
    endtask : read
endmodule : host_bus_model
`default_nettype wire

// ---- src/dsp_list_control_status.sv ----
// control and status registers of the command-list signal engine
`timescale 1ns/100ps
`default_nettype none
`include "dsp_list_params.svh"

module dsp_list_control_status (
    input wire logic sys_clk,
    input wire logic rst,
    input wire dsp_list_pkg::word_t host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire dsp_list_pkg::word_t host_wdata,
    output dsp_list_pkg::word_t host_rdata,
    output logic host_rack,
    output logic list_start,
    output dsp_list_pkg::half_t list_pointer,
    output logic list_abort_pulse,
    output logic overflow_clear,
    input wire logic engine_done,
    input wire logic loop_load,
    input wire dsp_list_pkg::word_t loop_load_data,
    input wire logic decrement_jump_nonzero_step,
    output dsp_list_pkg::word_t loop_value,
    input wire logic offchip_req,
    output logic offchip_go,
    output logic list_stalled,
    input wire logic illegal_op,
    input wire logic nmi_pin_n,
    output logic list_running,
    output logic interrupt_out_pin_n,
    output logic nmi_request
);
    import dsp_list_pkg::*;

    // address decode, shared by the write and read paths
    function automatic region_e region_of(input word_t a);
        if (a >= `RAM_BASE && a < `RAM_END) begin
            region_of = RG_RAM;
        end else if (a >= `DED_BASE && a < `DED_END) begin
            region_of = RG_DED;
        end else if (a >= `CTL_BASE && a < `CTL_END) begin
            region_of = RG_CTL;
        end else begin
            region_of = RG_NONE;
        end
    endfunction : region_of

    exec_state_e state_q;
    word_t loop_q;
    half_t ptr_q;
    logic hold_q;
    logic halt_q;
    logic mask_q;
    logic [2:0] nm_src_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_prev_q;
    region_e acc_region;
    logic acc;
    logic faulted;
    logic wr_ok;
    logic rd_ok;
    logic abort_wr;
    logic ptr_wr;
    logic stop_evt;
    logic pin_fall;
    word_t rdata_d;

    // a host access is faulted while running only if it hits the RAM or the dedicated registers
    assign acc_region = region_of(host_addr);
    assign acc = host_wr | host_rd;
    assign faulted = acc && state_q == ST_RUN
        && (acc_region == RG_RAM || acc_region == RG_DED);
    assign wr_ok = host_wr && !faulted;
    assign rd_ok = host_rd && !faulted;
    assign abort_wr = host_wr && host_addr == `ABORT_ADDR;
    assign ptr_wr = wr_ok && host_addr == `LIST_PTR_ADDR;
    // a stop event is a running list finishing; an abort is not counted as one
    assign stop_evt = (state_q == ST_RUN) && engine_done;
    // only the second stage is read, never the first
    assign pin_fall = pin_prev_q && !pin_sync_q;

    // run state: start on pointer write, stop on done or abort
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (ptr_wr && !abort_wr) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (abort_wr || engine_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // list pointer, written by the host only while idle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ptr_q <= `REG16_RESET;
        end else if (ptr_wr) begin
            ptr_q <= host_wdata[15:0];
        end
    end

    // loop register: engine load wins over a same-cycle decrement
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            loop_q <= `REG32_RESET;
        end else if (loop_load) begin
            loop_q <= loop_load_data;
        end else if (wr_ok && host_addr == `LOOP_ADDR) begin
            loop_q <= host_wdata;
        end else if (decrement_jump_nonzero_step) begin
            // count wraps from zero; the engine tests it before stepping
            loop_q[`COUNT_MSB:`COUNT_LSB] <= loop_q[`COUNT_MSB:`COUNT_LSB] - 16'h0001;
        end
    end

    // off-chip gate hold bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_q <= 1'b0;
        end else if (abort_wr) begin
            hold_q <= 1'b0;
        end else if (wr_ok && host_addr == `GATE_ADDR) begin
            hold_q <= host_wdata[`HOLD_BIT];
        end
    end

    // grant or stall each off-chip reference against the hold bit
    // the stall is a level; the engine keeps its request up until it is granted
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            offchip_go <= 1'b0;
            list_stalled <= 1'b0;
        end else begin
            offchip_go <= offchip_req && !hold_q && !abort_wr;
            list_stalled <= offchip_req && hold_q && !abort_wr;
        end
    end

    // halt status: stop sets it and beats a read clear, abort beats both
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halt_q <= 1'b0;
        end else if (abort_wr) begin
            halt_q <= 1'b0;
        end else if (stop_evt) begin
            halt_q <= 1'b1;
        end else if (rd_ok && host_addr == `IRQ_STATUS_ADDR) begin
            halt_q <= 1'b0;
        end
    end

    // halt mask
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask_q <= 1'b0;
        end else if (abort_wr) begin
            mask_q <= 1'b0;
        end else if (wr_ok && host_addr == `IRQ_MASK_ADDR) begin
            mask_q <= host_wdata[`HALT_BIT];
        end
    end

    // two-stage synchroniser and edge history for the nonmaskable pin
    // the first stage may be metastable, so only the second stage is read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
            pin_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= nmi_pin_n;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // nonmaskable sources: new events survive a same-cycle read clear
    // a nested handler may empty the register before the outer one reads it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nm_src_q <= 3'h0;
        end else begin
            if (rd_ok && host_addr == `NM_SOURCE_ADDR) begin
                nm_src_q <= 3'h0;
            end
            if (faulted) begin
                nm_src_q[`NM_FAULT_BIT] <= 1'b1;
            end
            if (illegal_op) begin
                nm_src_q[`NM_ILLEGAL_BIT] <= 1'b1;
            end
            if (pin_fall) begin
                nm_src_q[`NM_PIN_BIT] <= 1'b1;
            end
        end
    end

    // read mux; byte lane 0 is the byte at the word's own address
    always_comb begin
        rdata_d = `REG32_RESET;
        case (host_addr)
            `LOOP_ADDR: rdata_d = loop_q;
            `LIST_PTR_ADDR: rdata_d = {16'h0000, ptr_q};
            `EXEC_STATUS_ADDR: rdata_d[`RUN_BIT] = (state_q == ST_RUN);
            `IRQ_STATUS_ADDR: rdata_d[`HALT_BIT] = halt_q;
            `IRQ_MASK_ADDR: rdata_d[`HALT_BIT] = mask_q;
            `GATE_ADDR: rdata_d[`HOLD_BIT] = hold_q;
            `NM_SOURCE_ADDR: rdata_d[2:0] = nm_src_q;
            default: rdata_d = `REG32_RESET;
        endcase
        if (!rd_ok) begin
            rdata_d = `REG32_RESET;
        end
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_rdata <= `REG32_RESET;
            host_rack <= 1'b0;
        end else begin
            host_rdata <= rdata_d;
            host_rack <= host_rd;
        end
    end

    // engine-facing strobes and levels, all registered
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            list_start <= 1'b0;
            list_abort_pulse <= 1'b0;
            overflow_clear <= 1'b0;
            list_running <= 1'b0;
            interrupt_out_pin_n <= 1'b1;
            nmi_request <= 1'b0;
        end else begin
            list_start <= ptr_wr && state_q == ST_IDLE && !abort_wr;
            list_abort_pulse <= abort_wr;
            overflow_clear <= abort_wr;
            list_running <= state_q == ST_RUN;
            interrupt_out_pin_n <= !(halt_q && mask_q);
            nmi_request <= |nm_src_q;
        end
    end

    assign list_pointer = ptr_q;
    assign loop_value = loop_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence abort_seq;
        host_wr && host_addr == `ABORT_ADDR;
    endsequence

    sequence pin_fall_seq;
        nmi_pin_n ##1 (!nmi_pin_n)[*3];
    endsequence

    chk_abort_clears_all: assert property (abort_seq |=>
        state_q == ST_IDLE && !hold_q && !halt_q && !mask_q && list_abort_pulse)
        else $error("abort did not clear state");
    chk_start_runs: assert property (ptr_wr && state_q == ST_IDLE && !abort_wr
        |=> list_start && state_q == ST_RUN ##1 list_running)
        else $error("pointer write did not start list");
    chk_stop_sets_halt: assert property (stop_evt && !abort_wr |=> halt_q)
        else $error("stop did not set halt");
    chk_irq_pin_level: assert property (halt_q && mask_q |=> !interrupt_out_pin_n)
        else $error("interrupt pin not asserted");
    chk_nmi_request_out: assert property ((|nm_src_q) |=> nmi_request)
        else $error("nonmaskable request missing");
    chk_pin_edge_sets: assert property (pin_fall_seq |=> nm_src_q[`NM_PIN_BIT])
        else $error("pin falling edge missed");
    chk_hold_stalls: assert property (offchip_req && hold_q && !abort_wr
        |=> list_stalled && !offchip_go)
        else $error("hold did not stall reference");
    chk_gate_open: assert property (offchip_req && !hold_q && !abort_wr |=> offchip_go)
        else $error("open gate did not grant");
    chk_fault_flag_set: assert property (faulted |=> nm_src_q[`NM_FAULT_BIT]
        && ($past(loop_load || decrement_jump_nonzero_step) || $stable(loop_q)) && $stable(ptr_q))
        else $error("faulted access not flagged");
    chk_source_read_clear: assert property (rd_ok && host_addr == `NM_SOURCE_ADDR
        && !faulted && !illegal_op && !pin_fall |=> nm_src_q == 3'h0)
        else $error("source not cleared on read");
    chk_status_read_value: assert property (host_rd && host_addr == `EXEC_STATUS_ADDR
        |=> host_rack && host_rdata[`RUN_BIT] == $past(state_q == ST_RUN))
        else $error("run flag read wrong");
    chk_decrement_jump_nonzero_decrement: assert property (decrement_jump_nonzero_step && !loop_load
        && !(wr_ok && host_addr == `LOOP_ADDR)
        |=> loop_q[15:0] == $past(loop_q[15:0]) - 16'h0001)
        else $error("count not decremented");

    // register writes that land, and flags that must fall or hold again
    sequence mask_wr_seq;
        wr_ok && host_addr == `IRQ_MASK_ADDR && !abort_wr;
    endsequence

    sequence gate_wr_seq;
        wr_ok && host_addr == `GATE_ADDR && !abort_wr;
    endsequence

    sequence halt_rd_seq;
        rd_ok && host_addr == `IRQ_STATUS_ADDR;
    endsequence

    chk_mask_write_lands: assert property (mask_wr_seq
        |=> mask_q == $past(host_wdata[`HALT_BIT]))
        else $error("mask write lost");
    chk_gate_write_lands: assert property (gate_wr_seq
        |=> hold_q == $past(host_wdata[`HOLD_BIT]))
        else $error("gate write lost");
    chk_halt_read_clear: assert property (halt_rd_seq ##0 !stop_evt |=> !halt_q)
        else $error("halt status not cleared on read");
    // a stop reported while idle is refused and must not raise the halt flag
    chk_idle_done_ignored: assert property (state_q == ST_IDLE && engine_done
        && !abort_wr && !(rd_ok && host_addr == `IRQ_STATUS_ADDR) |=> $stable(halt_q))
        else $error("idle stop changed halt status");

    // source and request levels
    chk_illegal_sets_bit: assert property (illegal_op |=> nm_src_q[`NM_ILLEGAL_BIT])
        else $error("illegal command not flagged");
    chk_run_flag_lag: assert property (1'b1
        |=> list_running == $past(state_q == ST_RUN))
        else $error("run flag out of step");

    // abort and overflow-clear strobes only ever follow a real abort write
    chk_abort_pulse_only: assert property (!abort_wr
        |=> !list_abort_pulse && !overflow_clear)
        else $error("abort pulse without abort");
    chk_nmi_request_drop: assert property (!(|nm_src_q) |=> !nmi_request)
        else $error("nonmaskable request without source");
    chk_irq_pin_idle: assert property (!(halt_q && mask_q) |=> interrupt_out_pin_n)
        else $error("interrupt pin asserted without cause");
endmodule : dsp_list_control_status
`default_nettype wire
